// ### phy_status_consts.vh
/*
 * constants for the transceiver status register bank: word indices,
 * byte addresses, field positions, reset values and bus response codes.
 * assumes inclusion by phy_status_regs.v only.
 */
`ifndef PHY_STATUS_CONSTS_VH
`define PHY_STATUS_CONSTS_VH

`define ADDR_W            8
`define DATA_W            32
`define REG_W             16
// printed register numbers are word indices, byte address is four times
`define IDX_LIVE_STATUS   8'h11
`define IDX_CHANGE_FLAGS  8'h13
`define IDX_FAULT_SOURCES 8'h18
`define IDX_IRQ_STATUS    8'h1A
`define IDX_IRQ_MASK      8'h1B
`define ADDR_LIVE_STATUS  8'h44
`define ADDR_CHANGE_FLAGS 8'h4C
`define ADDR_FAULT_SRC    8'h60
`define ADDR_IRQ_STATUS   8'h68
`define ADDR_IRQ_MASK     8'h6C

// live status fields
`define LS_SPEED          14
`define LS_TX             13
`define LS_RX             12
`define LS_COL            11
`define LS_LINK           10
`define LS_DUPLEX         9
`define LS_AN_MODE        8
`define LS_AN_DONE        7
`define LS_POLARITY       5
`define LS_PAUSE          4
`define LS_ERROR          3

// change flag fields, also the interrupt layout
`define CF_NEG_DONE       7
`define CF_SPEED          6
`define CF_DUPLEX         5
`define CF_LINK           4
`define IRQ_FAULT         3
`define IRQ_W             8
`define IRQ_RESET         8'h00

// fault source fields
`define FS_REMOTE         0
`define FS_JABBER         1
`define FS_PARDET         2
`define FS_W              3

// synchronised input vector
`define SI_W              13
`define SI_REMOTE         10
`define SI_JABBER         11
`define SI_PARDET         12

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### phy_status_regs.v
/*
 * live transceiver status, sticky change flags, fault sources and
 * interrupt, all behind an axi4-lite slave.
 * assumes status inputs arrive from other clock domains or pins and are
 * synchronised here; one outstanding read and one write at a time.
 */
// The implementer's own choice: the AXI4-Lite register port.
// Operation
// - speed bit reads 1 while running 100BASE-TX, else 0, resets to 0.
// - transmit bit reads 1 while a packet is being sent.
// - receive bit reads 1 while a packet is being received.
// - collision bit reads 1 while a collision occurs on the medium.
// - link bit reads 1 while link is up, 0 when down.
// - duplex bit reads 1 in full duplex, 0 in half duplex.
// - negotiation mode bit reads 1 in auto-negotiation, 0 in manual mode.
// - completion bit mirrors negotiation complete; only meaningful with negotiation on.
// - polarity bit reads 1 when reversed; meaningless at 100 Mbps.
// - pause bit reads 1 when pause capable, resets to 0.
// - summary error bit set on remote fault, jabber or parallel detect fault.
// - summary error clears only by reading the fault source register.
// - negotiation done flag set on completion, cleared after a read.
// - speed change flag latched on speed change, cleared by reading flags.
// - duplex change flag latched on duplex change, cleared by reading flags.
// - link change flag latched on link change, cleared by reading flags.
`timescale 1ns/1ps
`include "phy_status_consts.vh"

module phy_status_regs (
  input  wire                 aclk,
  input  wire                 aresetn,
  // axi4-lite slave
  input  wire [`ADDR_W-1:0]   s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  input  wire [`DATA_W-1:0]   s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [`ADDR_W-1:0]   s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  output reg  [`DATA_W-1:0]   s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // live state from the transceiver core
  input  wire                 speed_100,
  input  wire                 tx_active,
  input  wire                 rx_active,
  input  wire                 collision,
  input  wire                 link_up,
  input  wire                 full_duplex,
  input  wire                 autoneg_mode,
  input  wire                 autoneg_complete,
  input  wire                 polarity_reversed,
  input  wire                 pause_capable,
  input  wire                 remote_fault,
  input  wire                 jabber,
  input  wire                 parallel_detect_fault,
  output reg                  irq
);

////////////////////////////////////////////////////////////////////////////
// input synchronisers

wire [`SI_W-1:0] raw_in;
reg  [`SI_W-1:0] sync1_r;
reg  [`SI_W-1:0] sync2_r;

assign raw_in = {parallel_detect_fault, jabber, remote_fault, pause_capable,
                 polarity_reversed, autoneg_complete, autoneg_mode, full_duplex,
                 link_up, collision, rx_active, tx_active, speed_100};

genvar gi;
generate
  for (gi = 0; gi < `SI_W; gi = gi + 1) begin : g_sync
    always @(posedge aclk) begin
      if (!aresetn) begin
        sync1_r[gi] <= 1'b0;
        sync2_r[gi] <= 1'b0;
      end else begin
        sync1_r[gi] <= raw_in[gi];
        sync2_r[gi] <= sync1_r[gi];
      end
    end
  end
endgenerate

wire s_speed    = sync2_r[0];
wire s_tx       = sync2_r[1];
wire s_rx       = sync2_r[2];
wire s_col      = sync2_r[3];
wire s_link     = sync2_r[4];
wire s_duplex   = sync2_r[5];
wire s_an_mode  = sync2_r[6];
wire s_an_done  = sync2_r[7];
wire s_polarity = sync2_r[8];
wire s_pause    = sync2_r[9];
wire [`FS_W-1:0] s_faults = sync2_r[`SI_PARDET:`SI_REMOTE];

////////////////////////////////////////////////////////////////////////////
// change detection

reg              prev_speed_r;
reg              prev_duplex_r;
reg              prev_link_r;
reg              prev_an_done_r;

always @(posedge aclk) begin
  if (!aresetn) begin
    prev_speed_r   <= 1'b0;
    prev_duplex_r  <= 1'b0;
    prev_link_r    <= 1'b0;
    prev_an_done_r <= 1'b0;
  end else begin
    prev_speed_r   <= s_speed;
    prev_duplex_r  <= s_duplex;
    prev_link_r    <= s_link;
    prev_an_done_r <= s_an_done;
  end
end

wire ev_speed    = s_speed ^ prev_speed_r;
wire ev_duplex   = s_duplex ^ prev_duplex_r;
wire ev_link     = s_link ^ prev_link_r;
wire ev_neg_done = s_an_done & ~prev_an_done_r;

////////////////////////////////////////////////////////////////////////////
// write channel

reg                 aw_held_r;
reg  [`ADDR_W-1:0]  awaddr_r;
reg                 w_held_r;
reg  [`DATA_W-1:0]  wdata_r;
reg  [3:0]          wstrb_r;
wire                do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

wire wr_live  = awaddr_r == `ADDR_LIVE_STATUS;
wire wr_chg   = awaddr_r == `ADDR_CHANGE_FLAGS;
wire wr_fault = awaddr_r == `ADDR_FAULT_SRC;
wire wr_istat = awaddr_r == `ADDR_IRQ_STATUS;
wire wr_imask = awaddr_r == `ADDR_IRQ_MASK;
wire wr_known = wr_live | wr_chg | wr_fault | wr_istat | wr_imask;

always @(posedge aclk) begin
  if (!aresetn) begin
    aw_held_r     <= 1'b0;
    awaddr_r      <= {`ADDR_W{1'b0}};
    w_held_r      <= 1'b0;
    wdata_r       <= {`DATA_W{1'b0}};
    wstrb_r       <= 4'h0;
    s_axi_awready <= 1'b0;
    s_axi_wready  <= 1'b0;
    s_axi_bvalid  <= 1'b0;
    s_axi_bresp   <= `RESP_OKAY;
  end else begin
    if (!aw_held_r && !s_axi_bvalid && !s_axi_awready)
      s_axi_awready <= 1'b1;
    if (!w_held_r && !s_axi_bvalid && !s_axi_wready)
      s_axi_wready <= 1'b1;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r     <= 1'b1;
      awaddr_r      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_r     <= 1'b1;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    if (do_write) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      s_axi_bvalid <= 1'b1;
      // read-only status registers take the write silently, unmapped ones refuse it
      s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// read channel decode and side effects

wire rd_take  = s_axi_arvalid & s_axi_arready;
wire rd_live  = s_axi_araddr == `ADDR_LIVE_STATUS;
wire rd_chg   = s_axi_araddr == `ADDR_CHANGE_FLAGS;
wire rd_fault = s_axi_araddr == `ADDR_FAULT_SRC;
wire rd_istat = s_axi_araddr == `ADDR_IRQ_STATUS;
wire rd_imask = s_axi_araddr == `ADDR_IRQ_MASK;
wire rd_known = rd_live | rd_chg | rd_fault | rd_istat | rd_imask;

wire chg_read   = rd_take & rd_chg;
wire fault_read = rd_take & rd_fault;

////////////////////////////////////////////////////////////////////////////
// sticky change flags and fault sources

reg  [3:0]        chg_r;
reg  [`FS_W-1:0]  fault_r;
wire [3:0]        chg_ev = {ev_neg_done, ev_speed, ev_duplex, ev_link};
wire [`FS_W-1:0]  fault_ev = s_faults & ~fault_r;

always @(posedge aclk) begin
  if (!aresetn) begin
    chg_r   <= 4'h0;
    fault_r <= {`FS_W{1'b0}};
  end else begin
    // a new event beats the clear so a read never hides it
    chg_r   <= (chg_read ? 4'h0 : chg_r) | chg_ev;
    // only the source register read clears, and a held fault re-latches
    fault_r <= (fault_read ? {`FS_W{1'b0}} : fault_r) | s_faults;
  end
end

wire error_summary = |fault_r;

////////////////////////////////////////////////////////////////////////////
// interrupt status, mask and output

reg  [`IRQ_W-1:0] irq_stat_r;
reg  [`IRQ_W-1:0] irq_mask_r;
wire [`IRQ_W-1:0] irq_ev;
wire [`IRQ_W-1:0] irq_clr;

assign irq_ev = {chg_ev, |fault_ev, 3'h0};
assign irq_clr = (do_write && wr_istat && wstrb_r[0]) ? wdata_r[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

always @(posedge aclk) begin
  if (!aresetn) begin
    irq_stat_r <= `IRQ_RESET;
    irq_mask_r <= `IRQ_RESET;
    irq        <= 1'b0;
  end else begin
    irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
    if (do_write && wr_imask && wstrb_r[0])
      irq_mask_r <= wdata_r[`IRQ_W-1:0];
    irq <= |(irq_stat_r & irq_mask_r);
  end
end

////////////////////////////////////////////////////////////////////////////
// read data

reg [`REG_W-1:0] live_word;
reg [`REG_W-1:0] chg_word;
reg [`DATA_W-1:0] rd_mux;

always @* begin
  // unlisted bits stay zero
  live_word = {`REG_W{1'b0}};
  live_word[`LS_SPEED]    = s_speed;
  live_word[`LS_TX]       = s_tx;
  live_word[`LS_RX]       = s_rx;
  live_word[`LS_COL]      = s_col;
  live_word[`LS_LINK]     = s_link;
  live_word[`LS_DUPLEX]   = s_duplex;
  live_word[`LS_AN_MODE]  = s_an_mode;
  live_word[`LS_AN_DONE]  = s_an_done;
  live_word[`LS_POLARITY] = s_polarity;
  live_word[`LS_PAUSE]    = s_pause;
  live_word[`LS_ERROR]    = error_summary;
  chg_word = {`REG_W{1'b0}};
  chg_word[`CF_NEG_DONE:`CF_LINK] = chg_r;
  rd_mux = {`DATA_W{1'b0}};
  case (1'b1)
    rd_live:  rd_mux[`REG_W-1:0] = live_word;
    rd_chg:   rd_mux[`REG_W-1:0] = chg_word;
    rd_fault: rd_mux[`FS_W-1:0]  = fault_r;
    rd_istat: rd_mux[`IRQ_W-1:0] = irq_stat_r;
    rd_imask: rd_mux[`IRQ_W-1:0] = irq_mask_r;
    default:  rd_mux = {`DATA_W{1'b0}};
  endcase
end

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid  <= 1'b0;
    s_axi_rdata   <= {`DATA_W{1'b0}};
    s_axi_rresp   <= `RESP_OKAY;
  end else begin
    if (!s_axi_rvalid && !s_axi_arready)
      s_axi_arready <= 1'b1;
    if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
end

endmodule

// ### phy_status_chk.sv
/* checker for phy_status_regs: live status and change flag read data.
   assumes a bind onto that module; port names match its own. */
`timescale 1ns/1ps
module phy_status_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        speed_100,
  input wire logic        tx_active,
  input wire logic        rx_active,
  input wire logic        collision,
  input wire logic        link_up,
  input wire logic        full_duplex,
  input wire logic        autoneg_mode,
  input wire logic        autoneg_complete,
  input wire logic        polarity_reversed,
  input wire logic        pause_capable
);
  wire  [9:0]  pin = {speed_100, tx_active, rx_active, collision, link_up, full_duplex,
                      autoneg_mode, autoneg_complete, polarity_reversed, pause_capable};
  wire  [31:0] d = s_axi_rdata;
  wire         ar = s_axi_arvalid && s_axi_arready;
  logic [9:0]  pin_r;
  logic [2:0]  quiet_r;
  // only judge reads whose pins sat still well past the sync flops
  wire         calm = ar && s_axi_araddr == 8'h44 && quiet_r > 3'h3 && pin == pin_r;
  always @(posedge aclk) begin
    pin_r <= pin;
    if (!aresetn || pin != pin_r)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SPEED: assert property (calm |=> d[14] == pin_r[9])
    else $error("speed bit");
  AST_ACTIVITY: assert property (calm |=> d[13:11] == pin_r[8:6])
    else $error("activity bits");
  AST_LINK_MODE: assert property (calm |=> d[10:8] == pin_r[5:3])
    else $error("link or mode bits");
  AST_NEG_DONE: assert property (calm |=> d[7] == pin_r[2])
    else $error("negotiation bit");
  AST_POLARITY: assert property (calm |=> d[5] == pin_r[1])
    else $error("polarity bit");
  AST_PAUSE: assert property (calm |=> d[4] == pin_r[0])
    else $error("pause bit");
  AST_RESV_LIVE: assert property (ar && s_axi_araddr == 8'h44 |=>
    d[31:15] == 17'h0 && !d[6] && d[2:0] == 3'h0) else $error("live reserved bits");
  AST_RESV_CHG: assert property (ar && s_axi_araddr == 8'h4C |=>
    d[31:8] == 24'h0 && d[3:0] == 4'h0) else $error("change reserved bits");
  cover property (calm);
  cover property (ar && s_axi_araddr == 8'h4C);
  cover property (s_axi_rvalid);
endmodule

// ### axi_host.sv
/* axi4-lite master model: one write or one read at a time.
   assumes tb_top provides tally_and_finish for a stuck bus. */
`timescale 1ns/1ps
module axi_host (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid} = '0;
  initial {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 7'h0F;
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int i;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 64 && !s_axi_bvalid; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    // released payload must not look valid
    s_axi_wdata  <= ~v;
    s_axi_awaddr <= ~a;
    resp = s_axi_bresp;
    if (i == 64) tb_top.tally_and_finish(1);
  endtask
  // lag stalls rready so rvalid must stand
  task automatic rd(input logic [7:0] a, input int lag, output logic [33:0] got);
    int i;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 64 && !(s_axi_rvalid && s_axi_rready); i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (i == lag) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    s_axi_araddr <= ~a;
    got = {s_axi_rresp, s_axi_rdata};
    if (i == 64) tb_top.tally_and_finish(1);
  endtask
endmodule

// ### tb_top.sv
/* top bench for phy_status_regs: random pins, change flags, faults, irq.
   assumes axi_host as master and phy_status_chk bound below. */
`timescale 1ns/1ps
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [12:0] pv = 13'h0000;
  logic [12:0] old;
  logic [31:0] seed = 32'h4712;
  logic [33:0] got;
  logic [1:0]  resp;
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  wire         speed_100, tx_active, rx_active, collision, link_up, full_duplex, autoneg_mode;
  wire         autoneg_complete, polarity_reversed, pause_capable, parallel_detect_fault, jabber, remote_fault;
  assign {speed_100, tx_active, rx_active, collision, link_up, full_duplex, autoneg_mode, autoneg_complete,
          polarity_reversed, pause_capable, parallel_detect_fault, jabber, remote_fault} = pv;
  phy_status_regs u_phy_status_regs (.*);
  axi_host        u_axi_host (.*);
  always #20 aclk = ~aclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] live(input logic [12:0] v, input logic err);
    return {17'h0, v[12:5], 1'b0, v[4:3], err, 3'h0};
  endfunction
  function automatic logic [31:0] chg(input logic [12:0] o, input logic [12:0] v);
    return {24'h0, ~o[5] & v[5], o[12] ^ v[12], o[7] ^ v[7], o[8] ^ v[8], 4'h0};
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [33:0] exp);
    seed = xs(seed);
    u_axi_host.rd(a, seed[1:0], got);
    check(got, exp);
  endtask
  // pins settle through sync flops before anything is read
  task automatic setp(input logic [12:0] v);
    @(posedge aclk);
    pv <= v;
    repeat (6) @(posedge aclk);
  endtask
  task automatic irqchk(input logic e);
    repeat (3) @(posedge aclk);
    check({33'h0, irq}, {33'h0, e});
  endtask
  task automatic tally_and_finish(input int extra);
    n_fail += extra;
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h44, 34'h0);
    rchk(8'h4C, 34'h0);
    for (int n = 0; n < 40; n++) begin
      seed = xs(seed);
      old = pv;
      setp({seed[12:3], 3'h0});
      rchk(8'h44, {2'h0, live(pv, 1'b0)});
      rchk(8'h4C, {2'h0, chg(old, pv)});
    end
    u_axi_host.wr(8'h44, 32'hFFFFFFFF, resp);
    check({32'h0, resp}, 34'h0);
    rchk(8'h44, {2'h0, live(pv, 1'b0)});
    u_axi_host.wr(8'h70, 32'h0, resp);
    check({32'h0, resp}, 34'h2);
    rchk(8'h70, 34'h200000000);
    for (int k = 0; k < 3; k++) begin
      setp(pv | (13'h1 << k));
      setp(pv & 13'h1FF8);
      rchk(8'h44, {2'h0, live(pv, 1'b1)});
      rchk(8'h44, {2'h0, live(pv, 1'b1)});
      rchk(8'h60, {2'h0, 32'h1 << k});
      rchk(8'h44, {2'h0, live(pv, 1'b0)});
    end
    u_axi_host.wr(8'h6C, 32'h10, resp);
    u_axi_host.wr(8'h68, 32'hFF, resp);
    irqchk(1'b0);
    setp(pv ^ 13'h0100);
    irqchk(1'b1);
    rchk(8'h4C, 34'h10);
    u_axi_host.wr(8'h6C, 32'h0, resp);
    irqchk(1'b0);
    u_axi_host.wr(8'h6C, 32'h10, resp);
    irqchk(1'b1);
    u_axi_host.wr(8'h68, 32'h10, resp);
    irqchk(1'b0);
    // link event lands on the very edge that takes the flag read
    @(posedge aclk);
    pv <= pv ^ 13'h0100;
    @(posedge aclk);
    u_axi_host.rd(8'h4C, 0, got);
    check(got, 34'h0);
    rchk(8'h4C, 34'h10);
    tally_and_finish(0);
  end
endmodule
bind phy_status_regs phy_status_chk u_phy_status_chk (.*);
